// ==== ardr_pkg.sv ====
// constants and types for the acceleration/deceleration ramp generator
package ardr_pkg;
    // clock and control tick
    localparam int CLK_MHZ  = 40;
    localparam int TICK_US  = 1000;
    localparam int TICK_CYC = CLK_MHZ * TICK_US;
    // ramp time setting unit is 0.1 s, i.e. this many ticks
    localparam int TIME_UNIT_MS   = 100;
    localparam int TICKS_PER_UNIT = (TIME_UNIT_MS * 1000) / TICK_US;
    // ramp shape selections
    localparam logic [1:0] SHAPE_LINEAR = 2'h0;
    localparam logic [1:0] SHAPE_S_BASE = 2'h1;
    localparam logic [1:0] SHAPE_S_EACH = 2'h2;
    // automatic ramp mode selections
    localparam logic [3:0] AUTO_NORMAL   = 4'h0;
    localparam logic [3:0] AUTO_NO_BRAKE = 4'h1;
    localparam logic [3:0] AUTO_SEQ1     = 4'h7;
    localparam logic [3:0] AUTO_SEQ2     = 4'h8;
    localparam logic [3:0] AUTO_BRAKE    = 4'hB;
    // direction selections for the automatic mode
    localparam logic [1:0] DIR_BOTH  = 2'h0;
    localparam logic [1:0] DIR_ACCEL = 2'h1;
    localparam logic [1:0] DIR_DECEL = 2'h2;
    // setting codes and ranges
    localparam logic [15:0] SENTINEL      = 16'h270F;
    localparam logic [15:0] DEF_LIMIT_PCT = 16'h0096;
    localparam logic [15:0] PCT_FULL      = 16'h0064;
    localparam logic [15:0] MAX_REF_CUR   = 16'h1388;
    localparam logic [15:0] MAX_LIMIT_PCT = 16'h00C8;
    // slope weights, unity is 1 << W_SHIFT
    localparam int          W_SHIFT  = 8;
    localparam logic [15:0] W_UNITY  = 16'h0100;
    localparam logic [15:0] W_HALF   = 16'h0080;
    localparam logic [15:0] W_EDGE   = 16'h0080;
    localparam logic [15:0] W_MID    = 16'h0200;
    localparam int          AUTO_SH  = 2;
    localparam int          BRAKE_SH = 3;
    localparam logic [2:0]  EDGE_PAD = 3'h0;
    // ramp sequencer states
    typedef enum logic [0:0] {
        ST_WAIT = 1'b0,
        ST_STEP = 1'b1
    } ardr_state_e;
endpackage

// ==== ardr_ramp_gen.sv ====
// output frequency ramp generator with s-curves and shortest ramping
`timescale 1ns/1ps
// Functional notes
// RQ1: shape 0 ramps linearly at constant slope, both directions.
// RQ2: shape 1 is an s-curve bending at base frequency, slower above it.
// RQ3: in shape 1 the ramp time means time to reach base frequency.
// RQ4: shape 2 makes every frequency change a fresh s-curve segment.
// RQ5: a shape 2 segment never takes longer than the linear ramp.
// RQ6: auto mode 0 normal, 1 shortest, 11 shortest with brake, 7/8 sequence.
// RQ7: direction select 0 both, 1 acceleration only, 2 deceleration only.
// RQ8: shortest mode derives its rate from stored times, times untouched.
// RQ9: limit sentinel means 150 percent of reference current.
// RQ10: general stall level in shortest mode only at constant speed; code also uses it on ramps the direction select excludes.
// RQ11: reference current 0 to 500 A; sentinel means rated current.
// RQ12: limits 0 to 200 percent of reference current, per direction.
// RQ13: jog or second function while stopped in auto forces normal ramping.
// RQ14: jog and second function are ignored while running in auto.
// RQ15: changing auto mode resets reference current and limits to sentinel.
// RQ16: second function select picks the alternate ramp times.
// RQ17: output steps one unit per clock while tick credit lasts, toward target, holds, never overshoots.
module ardr_ramp_gen #(
    parameter int TICK_CYCLES = ardr_pkg::TICK_CYC
) (
    input  wire logic        CLK_I,
    input  wire logic        NRST_I,
    input  wire logic        START_I,
    input  wire logic        JOG_I,
    input  wire logic        SECOND_FUNCTION_SELECT_I,
    input  wire logic [15:0] SET_FREQ_I,
    input  wire logic [15:0] JOG_FREQ_I,
    input  wire logic [15:0] MOTOR_CURRENT_I,
    input  wire logic [15:0] RATED_CURRENT_I,
    input  wire logic [1:0]  RAMP_SHAPE_SELECT_I,
    input  wire logic [3:0]  AUTO_RAMP_MODE_I,
    input  wire logic [1:0]  AUTO_RAMP_DIRECTION_SELECT_I,
    input  wire logic [15:0] ACCEL_TIME_SETTING_I,
    input  wire logic [15:0] DECEL_TIME_SETTING_I,
    input  wire logic [15:0] ACCEL_TIME2_SETTING_I,
    input  wire logic [15:0] DECEL_TIME2_SETTING_I,
    input  wire logic [15:0] BASE_FREQUENCY_SETTING_I,
    input  wire logic [15:0] RAMP_REFERENCE_FREQUENCY_I,
    input  wire logic [15:0] STALL_PREVENTION_LEVEL_I,
    input  wire logic        LIMIT_WR_I,
    input  wire logic [15:0] RAMP_REFERENCE_CURRENT_I,
    input  wire logic [15:0] ACCEL_CURRENT_LIMIT_I,
    input  wire logic [15:0] DECEL_CURRENT_LIMIT_I,
    output logic      [15:0] OUT_FREQ_O,
    output logic             RAMP_ACTIVE_O,
    output logic             STALL_ACTIVE_O,
    output logic             AUTO_ACTIVE_O,
    output logic      [15:0] REF_CURRENT_O,
    output logic      [15:0] ACCEL_LIMIT_O,
    output logic      [15:0] DECEL_LIMIT_O
);
    import ardr_pkg::*;

    typedef struct packed {
        ardr_state_e st;
        logic [31:0] tick_cnt;
        logic [15:0] freq;
        logic [31:0] acc;
        logic [15:0] seg_start;
        logic [15:0] seg_target;
        logic [15:0] ref_cur;
        logic [15:0] acc_lim;
        logic [15:0] dec_lim;
        logic [3:0]  mode_prev;
        logic        ovr;
        logic        jog_eff;
        logic        rt_eff;
        logic        ramping;
        logic        stall;
        logic        auto_act;
    } ardr_state_s;

    ardr_state_s r_q;
    ardr_state_s r_d;

    logic        tick;
    logic        stopped;
    logic        auto_mode;
    logic        follow;
    logic        accel;
    logic        ramping;
    logic        auto_dir;
    logic        edge_zone;
    logic        ramp_hit;
    logic        const_hit;
    logic        stall_c;
    logic [15:0] target;
    logic [15:0] time_set;
    logic [15:0] ref_f;
    logic [15:0] w;
    logic [15:0] ref_a;
    logic [15:0] lim_pct;
    logic [15:0] span;
    logic [15:0] done_d;
    logic [15:0] left_d;
    logic [31:0] time_ticks;
    logic [31:0] inc;
    logic [31:0] cur_x100;

    function automatic logic [15:0] absdiff(input logic [15:0] a,
                                            input logic [15:0] b);
        absdiff = (a > b) ? a - b : b - a;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // control tick divider and operating condition
    assign tick      = r_q.tick_cnt == 32'(TICK_CYCLES - 1);
    assign stopped   = r_q.freq == 16'h0000;
    // RQ6 mode decode, sequence modes ramp normally
    assign auto_mode = (AUTO_RAMP_MODE_I == AUTO_NO_BRAKE) ||
                       (AUTO_RAMP_MODE_I == AUTO_BRAKE);
    assign follow    = !auto_mode || stopped || r_q.ovr;
    assign target    = r_q.jog_eff ? JOG_FREQ_I :
                       (START_I ? SET_FREQ_I : 16'h0000);
    assign accel     = target > r_q.freq;
    assign ramping   = target != r_q.freq;
    // RQ7 direction select
    assign auto_dir  = auto_mode && !r_q.ovr &&
                       ((AUTO_RAMP_DIRECTION_SELECT_I == DIR_BOTH) ||
                        (AUTO_RAMP_DIRECTION_SELECT_I == DIR_ACCEL
                         && accel) ||
                        (AUTO_RAMP_DIRECTION_SELECT_I == DIR_DECEL
                         && !accel));

    ////////////////////////////////////////////////////////////////////////
    // RQ16 ramp time choice
    always_comb begin
        if (r_q.rt_eff) begin
            time_set = accel ? ACCEL_TIME2_SETTING_I : DECEL_TIME2_SETTING_I;
        end else begin
            time_set = accel ? ACCEL_TIME_SETTING_I : DECEL_TIME_SETTING_I;
        end
    end

    // RQ8 stored times only read, zero treated as one unit
    assign time_ticks = 32'((time_set == 16'h0000) ? 16'h0001 : time_set)
                        * 32'(TICKS_PER_UNIT);

    ////////////////////////////////////////////////////////////////////////
    // RQ11 reference current, sentinel picks rated current
    assign ref_a     = (r_q.ref_cur == SENTINEL) ? RATED_CURRENT_I
                                                 : r_q.ref_cur;
    // RQ9 limit sentinel gives 150 percent
    assign lim_pct   = ((accel ? r_q.acc_lim : r_q.dec_lim) == SENTINEL)
                       ? DEF_LIMIT_PCT
                       : (accel ? r_q.acc_lim : r_q.dec_lim);
    assign cur_x100  = 32'(MOTOR_CURRENT_I) * 32'(PCT_FULL);
    // RQ12 limit as ratio of reference current
    assign ramp_hit  = cur_x100 >= 32'(ref_a) * 32'(lim_pct);
    assign const_hit = cur_x100 >= 32'(RATED_CURRENT_I)
                                   * 32'(STALL_PREVENTION_LEVEL_I);
    // RQ10 general level except while ramping in a direction that shortest mode covers
    assign stall_c   = (auto_dir && ramping) ? ramp_hit : const_hit;

    ////////////////////////////////////////////////////////////////////////
    // segment position for per-change s-curves
    assign span      = absdiff(r_q.seg_target, r_q.seg_start);
    assign done_d    = absdiff(r_q.freq, r_q.seg_start);
    assign left_d    = absdiff(target, r_q.freq);
    assign edge_zone = ({done_d, EDGE_PAD} < {EDGE_PAD, span}) ||
                       ({left_d, EDGE_PAD} < {EDGE_PAD, span});

    // slope weight per shape and mode
    always_comb begin
        ref_f = RAMP_REFERENCE_FREQUENCY_I;
        w     = W_UNITY;
        case (RAMP_SHAPE_SELECT_I)
            // RQ2 bend at base frequency
            SHAPE_S_BASE: begin
                // RQ3 time refers to base frequency
                ref_f = BASE_FREQUENCY_SETTING_I;
                w     = (r_q.freq >= BASE_FREQUENCY_SETTING_I) ? W_HALF
                                                              : W_UNITY;
            end
            // RQ5 slow eighths, fast middle: 7/8 of linear time
            SHAPE_S_EACH: begin
                w = edge_zone ? W_EDGE : W_MID;
            end
            default: begin
                w = W_UNITY;
            end
        endcase
        // RQ8 shortest mode runs fast, held back by current limit
        if (auto_dir) begin
            if (!accel && AUTO_RAMP_MODE_I == AUTO_BRAKE) begin
                w = w << BRAKE_SH;
            end else begin
                w = w << AUTO_SH;
            end
        end
    end

    // RQ1 constant increment per tick
    assign inc = 32'((32'(ref_f) * 32'(w)) >> W_SHIFT);

    ////////////////////////////////////////////////////////////////////////
    // next state of the whole block
    always_comb begin
        r_d          = r_q;
        r_d.tick_cnt = tick ? 32'h0000_0000 : r_q.tick_cnt + 32'h0000_0001;
        r_d.mode_prev = AUTO_RAMP_MODE_I;
        // RQ15 mode change restores sentinels, wins over a write
        if (AUTO_RAMP_MODE_I != r_q.mode_prev) begin
            r_d.ref_cur = SENTINEL;
            r_d.acc_lim = SENTINEL;
            r_d.dec_lim = SENTINEL;
        end else if (LIMIT_WR_I) begin
            // RQ11 range check on reference current
            if (RAMP_REFERENCE_CURRENT_I <= MAX_REF_CUR ||
                RAMP_REFERENCE_CURRENT_I == SENTINEL) begin
                r_d.ref_cur = RAMP_REFERENCE_CURRENT_I;
            end
            // RQ12 range check on limits
            if (ACCEL_CURRENT_LIMIT_I <= MAX_LIMIT_PCT ||
                ACCEL_CURRENT_LIMIT_I == SENTINEL) begin
                r_d.acc_lim = ACCEL_CURRENT_LIMIT_I;
            end
            if (DECEL_CURRENT_LIMIT_I <= MAX_LIMIT_PCT ||
                DECEL_CURRENT_LIMIT_I == SENTINEL) begin
                r_d.dec_lim = DECEL_CURRENT_LIMIT_I;
            end
        end
        // RQ13 override to normal ramping when stopped
        if (stopped) begin
            r_d.ovr = auto_mode && (JOG_I || SECOND_FUNCTION_SELECT_I);
        end
        // RQ14 hold jog and second function while running in auto
        if (follow) begin
            r_d.jog_eff = JOG_I;
            r_d.rt_eff  = SECOND_FUNCTION_SELECT_I;
        end
        // RQ4 new target opens a new segment
        if (target != r_q.seg_target) begin
            r_d.seg_start  = r_q.freq;
            r_d.seg_target = target;
        end
        // RQ17 credit added once per tick unless stalled
        if (!ramping) begin
            r_d.acc = 32'h0000_0000;
        end else if (tick && !stall_c) begin
            r_d.acc = r_q.acc + inc;
        end
        case (r_q.st)
            ST_WAIT: begin
                if (tick && ramping) begin
                    r_d.st = ST_STEP;
                end
            end
            ST_STEP: begin
                if (!ramping) begin
                    r_d.st = ST_WAIT;
                end else if (r_q.acc >= time_ticks) begin
                    // RQ17 one unit per step, stops on target
                    r_d.acc  = r_d.acc - time_ticks;
                    r_d.freq = accel ? r_q.freq + 16'h0001
                                     : r_q.freq - 16'h0001;
                end else begin
                    r_d.st = ST_WAIT;
                end
            end
            default: begin
                r_d.st = ST_WAIT;
            end
        endcase
        r_d.ramping  = ramping;
        r_d.stall    = stall_c;
        r_d.auto_act = auto_dir && ramping;
    end

    // state register
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            r_q           <= '0;
            r_q.ref_cur   <= SENTINEL;
            r_q.acc_lim   <= SENTINEL;
            r_q.dec_lim   <= SENTINEL;
            r_q.mode_prev <= AUTO_NORMAL;
        end else begin
            r_q <= r_d;
        end
    end

    // outputs straight from the state register
    assign OUT_FREQ_O     = r_q.freq;
    assign RAMP_ACTIVE_O  = r_q.ramping;
    assign STALL_ACTIVE_O = r_q.stall;
    assign AUTO_ACTIVE_O  = r_q.auto_act;
    assign REF_CURRENT_O  = r_q.ref_cur;
    assign ACCEL_LIMIT_O  = r_q.acc_lim;
    assign DECEL_LIMIT_O  = r_q.dec_lim;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);

    sequence s_tick_go;
        r_q.st == ST_WAIT && tick && ramping;
    endsequence
    sequence s_stepping;
        r_q.st == ST_STEP;
    endsequence

    a_tick_starts_step: assert property ( // RQ1
        s_tick_go |=> s_stepping)
        else $error("tick with pending ramp did not start stepping");
    a_freq_one_step: assert property ( // RQ17
        (r_q.freq != $past(r_q.freq)) |->
        (r_q.freq == $past(r_q.freq) + 16'h0001 ||
         r_q.freq == $past(r_q.freq) - 16'h0001))
        else $error("output frequency moved by more than one unit");
    a_freq_toward_tgt: assert property ( // RQ17
        (r_q.freq > $past(r_q.freq)) |-> $past(accel))
        else $error("output frequency rose past its target");
    a_mode_chg_reset: assert property ( // RQ15
        (AUTO_RAMP_MODE_I != r_q.mode_prev) |=>
        (REF_CURRENT_O == SENTINEL && ACCEL_LIMIT_O == SENTINEL &&
         DECEL_LIMIT_O == SENTINEL))
        else $error("mode change did not restore sentinels");
    a_jog_ignored_run: assert property ( // RQ14
        (auto_mode && !stopped && !r_q.ovr) |=>
        (r_q.jog_eff == $past(r_q.jog_eff) &&
         r_q.rt_eff == $past(r_q.rt_eff)))
        else $error("jog or second function taken while running in auto");
    a_stop_override: assert property ( // RQ13
        (auto_mode && stopped && (JOG_I || SECOND_FUNCTION_SELECT_I))
        |=> (r_q.ovr ##1 !AUTO_ACTIVE_O))
        else $error("stopped jog did not force normal ramping");
    a_stall_hold_acc: assert property ( // RQ8
        (s_tick_go and stall_c) |=> (r_q.acc == $past(r_q.acc)))
        else $error("ramp credit grew while current limit active");
    a_sentinel_150: assert property ( // RQ9
        (auto_dir && ramping && r_q.ref_cur == SENTINEL &&
         (accel ? r_q.acc_lim : r_q.dec_lim) == SENTINEL) |=>
        (STALL_ACTIVE_O == ($past(cur_x100) >=
         32'($past(RATED_CURRENT_I)) * 32'(DEF_LIMIT_PCT))))
        else $error("default ramp stall level is not 150 percent");
    a_const_level: assert property ( // RQ10
        !ramping |=> (STALL_ACTIVE_O == $past(const_hit)))
        else $error("constant speed stall level not applied");
endmodule

// ==== ardr_motor_model.sv ====
// power stage and motor: current feedback from load and frequency moves
`timescale 1ns/1ps
module ardr_motor_model #(
    parameter logic [15:0] SURGE = 16'h0005
) (
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic [15:0] freq_i,
    input  wire logic [15:0] load_i,
    output logic      [15:0] current_o
);
    logic [15:0] last_q;

    // extra current drawn while the commanded frequency moves
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            last_q    <= 16'h0000;
            current_o <= 16'h0000;
        end else begin
            last_q    <= freq_i;
            current_o <= load_i + ((freq_i != last_q) ? SURGE : 16'h0000);
        end
    end
endmodule

// ==== ardr_ramp_gen_test.sv ====
// ramp generator testbench: settings, shapes, shortest mode, jog
`timescale 1ns/1ps
module ardr_ramp_gen_test;
    import ardr_pkg::*;
    localparam int TC = 20; // shortened control tick
    logic        clk    = 1'b0;
    logic        nrst   = 1'b0;
    logic        st     = 1'b0;
    logic        jog    = 1'b0;
    logic        sfs    = 1'b0;
    logic        wr     = 1'b0;
    logic [1:0]  shape  = SHAPE_LINEAR;
    logic [3:0]  mode   = AUTO_NORMAL;
    logic [1:0]  dir    = DIR_BOTH;
    logic [15:0] set_f  = 16'h0000;
    logic [15:0] jog_f  = 16'h0028;
    logic [15:0] load   = 16'h0032;
    logic [15:0] rated  = 16'h0064;
    logic [15:0] t_acc  = 16'h0001;
    logic [15:0] t_dec  = 16'h0002;
    logic [15:0] t2     = 16'h0004;
    logic [15:0] base_f = 16'h000A;
    logic [15:0] ref_f  = 16'h00C8;
    logic [15:0] lvl    = 16'h00C8;
    logic [15:0] w_ref  = 16'h0000;
    logic [15:0] w_acc  = 16'h0000;
    logic [15:0] w_dec  = 16'h0000;
    logic [15:0] cur, out_f, ref_cur, acc_lim, dec_lim;
    logic        ramp_act, stall_act, auto_act, sh;
    logic [3:0]  modes [5] = '{4'h0, 4'h1, 4'h7, 4'h8, 4'hB};
    int          n_fail = 0;
    int          tests_run = 0;
    int          dl;

    always #12.5 clk = ~clk;

    ardr_ramp_gen #(.TICK_CYCLES(TC)) ardr_ramp_gen_inst (
        .CLK_I                       (clk),
        .NRST_I                      (nrst),
        .START_I                     (st),
        .JOG_I                       (jog),
        .SECOND_FUNCTION_SELECT_I    (sfs),
        .SET_FREQ_I                  (set_f),
        .JOG_FREQ_I                  (jog_f),
        .MOTOR_CURRENT_I             (cur),
        .RATED_CURRENT_I             (rated),
        .RAMP_SHAPE_SELECT_I         (shape),
        .AUTO_RAMP_MODE_I            (mode),
        .AUTO_RAMP_DIRECTION_SELECT_I(dir),
        .ACCEL_TIME_SETTING_I        (t_acc),
        .DECEL_TIME_SETTING_I        (t_dec),
        .ACCEL_TIME2_SETTING_I       (t2),
        .DECEL_TIME2_SETTING_I       (t2),
        .BASE_FREQUENCY_SETTING_I    (base_f),
        .RAMP_REFERENCE_FREQUENCY_I  (ref_f),
        .STALL_PREVENTION_LEVEL_I    (lvl),
        .LIMIT_WR_I                  (wr),
        .RAMP_REFERENCE_CURRENT_I    (w_ref),
        .ACCEL_CURRENT_LIMIT_I       (w_acc),
        .DECEL_CURRENT_LIMIT_I       (w_dec),
        .OUT_FREQ_O                  (out_f),
        .RAMP_ACTIVE_O               (ramp_act),
        .STALL_ACTIVE_O              (stall_act),
        .AUTO_ACTIVE_O               (auto_act),
        .REF_CURRENT_O               (ref_cur),
        .ACCEL_LIMIT_O               (acc_lim),
        .DECEL_LIMIT_O               (dec_lim)
    );

    ardr_motor_model ardr_motor_model_inst (
        .clk_i    (clk),
        .nrst_i   (nrst),
        .freq_i   (out_f),
        .load_i   (load),
        .current_o(cur)
    );

    ////////////////////////////////////////////////////////////////////////
    // wait edges, then leave the edge behind
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // exact value compare
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    // duration compare against a window
    task automatic chk_rng(input string nm, input int lo, input int hi,
                           input int g);
        tests_run++;
        if (g < lo || g > hi) begin
            n_fail++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask

    // one strobed write of the three limit settings
    task automatic wr_set(input logic [15:0] r, a, d);
        w_ref = r;
        w_acc = a;
        w_dec = d;
        wr = 1'b1;
        step(1);
        wr = 1'b0;
        step(2);
    endtask

    // command a ramp, time it, watch flags, overshoot and hold
    task automatic ramp(input logic s, input logic [15:0] f, fin,
                        input int lo, hi, input logic au, input string nm);
        int   n;
        logic up, ov;
        n = 0;
        up = fin > out_f;
        ov = 1'b0;
        st = s;
        set_f = f;
        while (out_f !== fin && n < 20000) begin
            step(1);
            n++;
            if (n == 20) chk({nm, " auto"}, 16'(au), 16'(auto_act));
            if (n == 20) chk({nm, " busy"}, 16'h0001, 16'(ramp_act));
            if (up ? out_f > fin : out_f < fin) ov = 1'b1;
        end
        chk_rng(nm, lo, hi, n);
        chk({nm, " over"}, 16'h0000, 16'(ov));
        step(3);
        chk({nm, " hold"}, fin, out_f);
    endtask

    task automatic test_done;
        if (n_fail == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // watchdog well beyond the expected run length
    initial begin
        #1250000;
        n_fail++;
        test_done();
    end

    // main sequence
    initial begin
        step(4);
        nrst = 1'b1;
        step(1);
        chk("ref rst", SENTINEL, ref_cur);
        chk("acc rst", SENTINEL, acc_lim);
        chk("out rst", 16'h0000, out_f);
        wr_set(16'h0064, 16'h0078, 16'h0050);
        chk("ref wr", 16'h0064, ref_cur);
        chk("acc wr", 16'h0078, acc_lim);
        wr_set(16'h1389, 16'h00C9, SENTINEL);
        chk("ref big", 16'h0064, ref_cur);
        chk("acc big", 16'h0078, acc_lim);
        chk("dec snt", SENTINEL, dec_lim);
        wr_set(16'h0064, 16'h0078, 16'h0050);
        mode = AUTO_NO_BRAKE;
        step(2);
        chk("ref mode", SENTINEL, ref_cur);
        chk("dec mode", SENTINEL, dec_lim);
        mode = AUTO_NORMAL;
        step(2);
        ramp(1, 16'h0028, 16'h0028, 375, 425, 0, "lin up");
        ramp(0, 16'h0028, 16'h0000, 775, 825, 0, "lin dn");
        sfs = 1'b1;
        ramp(1, 16'h0028, 16'h0028, 1575, 1625, 0, "rt up");
        ramp(0, 16'h0028, 16'h0000, 1575, 1625, 0, "rt dn");
        sfs = 1'b0;
        shape = SHAPE_S_EACH;
        ramp(1, 16'h0028, 16'h0028, 100, 425, 0, "s2 a");
        ramp(1, 16'h003C, 16'h003C, 50, 225, 0, "s2 b");
        ramp(0, 16'h003C, 16'h0000, 200, 1225, 0, "s2 c");
        shape = SHAPE_S_BASE;
        ramp(1, 16'h000A, 16'h000A, 1975, 2025, 0, "s1 base");
        ramp(1, 16'h0014, 16'h0014, 3975, 4025, 0, "s1 high");
        shape = SHAPE_LINEAR;
        ramp(0, 16'h0014, 16'h0000, 375, 425, 0, "s1 back");
        foreach (modes[i]) begin
            mode = modes[i];
            step(2);
            sh = mode == AUTO_NO_BRAKE || mode == AUTO_BRAKE;
            dl = mode == AUTO_BRAKE ? 100 : (sh ? 200 : 800);
            ramp(1, 16'h0028, 16'h0028, sh ? 75 : 375, sh ? 125 : 425, sh,
                 "mode up");
            ramp(0, 16'h0028, 16'h0000, dl - 25, dl + 25, sh,
                 "mode dn");
        end
        mode = AUTO_NO_BRAKE;
        for (int d = 1; d < 3; d++) begin
            dir = d[1:0];
            step(2);
            ramp(1, 16'h0028, 16'h0028, d == 1 ? 75 : 375, d == 1 ? 125 : 425,
                 d == 1, "dir up");
            ramp(0, 16'h0028, 16'h0000, d == 2 ? 175 : 775, d == 2 ? 225 : 825,
                 d == 2, "dir dn");
        end
        dir = DIR_BOTH;
        // default limit and constant speed level
        load = 16'h00A0;
        st = 1'b1;
        step(60);
        chk("stall hold", 16'h0000, out_f);
        chk("stall flag", 16'h0001, 16'(stall_act));
        load = 16'h008C;
        ramp(1, 16'h0028, 16'h0028, 75, 145, 1, "lim 150");
        load = 16'h00A0;
        step(3);
        chk("const lo", 16'h0000, 16'(stall_act));
        load = 16'h00D2;
        step(3);
        chk("const hi", 16'h0001, 16'(stall_act));
        load = 16'h0032;
        ramp(0, 16'h0028, 16'h0000, 175, 225, 1, "lim dn");
        wr_set(16'h00C8, 16'h0032, SENTINEL);
        load = 16'h0078;
        st = 1'b1;
        step(60);
        chk("acc lim", 16'h0000, out_f);
        load = 16'h003C;
        ramp(1, 16'h0028, 16'h0028, 75, 145, 1, "ref cur");
        load = 16'h0032;
        ramp(0, 16'h0028, 16'h0000, 175, 225, 1, "ref dn");
        // second function while stopped in auto, alternate times
        sfs = 1'b1;
        step(2);
        ramp(1, 16'h0028, 16'h0028, 1575, 1625, 0, "sfs up");
        ramp(0, 16'h0028, 16'h0000, 1575, 1625, 0, "sfs dn");
        sfs = 1'b0;
        jog = 1'b1;
        ramp(0, 16'h0000, 16'h0028, 375, 425, 0, "jog");
        nrst = 1'b0;
        jog = 1'b0;
        step(1);
        nrst = 1'b1;
        chk("out rst2", 16'h0000, out_f);
        step(2);
        chk("ref rst2", SENTINEL, ref_cur);
        // jog and second function ignored while running
        ramp(1, 16'h0028, 16'h0028, 75, 125, 1, "auto run");
        jog_f = 16'h0014;
        jog = 1'b1;
        sfs = 1'b1;
        step(100);
        chk("jog ign", 16'h0028, out_f);
        jog = 1'b0;
        ramp(0, 16'h0028, 16'h0000, 175, 225, 1, "auto dn");
        sfs = 1'b0;
        test_done();
    end
endmodule
